// file: rtl/cmc_pkg.sv
package cmc_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_CONTROL    = 16'hD7C0;
  localparam logic [15:0] IDX_STATUS     = 16'hD7C2;
  localparam logic [15:0] IDX_BIT_TIMING = 16'hD7C4;
  localparam logic [15:0] IDX_CLOCK_SEL  = 16'hD7C7;
  localparam logic [15:0] IDX_TIME_STAMP = 16'hD7D4;
  localparam logic [15:0] IDX_MASK_EN    = 16'hD7E0;

  // ==========================================================================
  // field encodings
  localparam logic [1:0] MODE_OPER  = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [1:0] MODE_HALT  = 2'h2;
  localparam logic [1:0] MODE_BAD   = 2'h3;
  localparam logic [1:0] BOR_NORMAL = 2'h0;
  localparam logic [1:0] BOR_ENTRY  = 2'h1;
  localparam logic [1:0] BOR_END    = 2'h2;
  localparam logic [1:0] IDF_BAD    = 2'h3;

  // ==========================================================================
  // control register bit positions of the one-shot command bits
  localparam int unsigned POS_FORCE_RET = 5;
  localparam int unsigned POS_TS_RESET  = 13;

  // status register bit positions
  localparam int unsigned POS_ST_RESET   = 0;
  localparam int unsigned POS_ST_HALT    = 1;
  localparam int unsigned POS_ST_SLEEP   = 2;
  localparam int unsigned POS_ST_ERRPAS  = 3;
  localparam int unsigned POS_ST_BUSOFF  = 4;
  localparam int unsigned POS_ST_TXACT   = 5;
  localparam int unsigned POS_ST_RXACT   = 6;
  localparam int unsigned POS_ST_RXFIFO  = 10;

  // ==========================================================================
  // control register layout, msb first
  typedef struct packed {
    logic [1:0] ts_pre;       // time stamp prescaler select
    logic       ts_rst;       // one-shot, always stored as zero
    logic       tx_prio;      // 0 id priority, 1 mailbox number priority
    logic       msg_lost;     // 0 overwrite, 1 overrun
    logic [1:0] id_fmt;       // standard, extended, mixed
    logic       mbox_fifo;    // 0 normal mailbox, 1 fifo mailbox
    logic [1:0] rsvd;         // reads zero
    logic       force_ret;    // one-shot, always stored as zero
    logic [1:0] busoff_mode;  // bus-off recovery policy
    logic       sleep;        // sleep request
    logic [1:0] mode;         // operating mode request
  } cmc_ctrl_t;

  localparam cmc_ctrl_t CTRL_RESET = 16'h0001;  // starts in reset mode
  localparam logic [9:0] BRP_RESET = 10'h000;
  localparam logic [7:0] MASK_EN_RESET = 8'h00;

  // actual controller mode
  typedef enum logic [1:0] {
    CMC_OPER,
    CMC_RESET,
    CMC_HALT,
    CMC_SLEEP
  } cmc_mode_t;

endpackage : cmc_pkg

// file: rtl/cmc_mode_ctrl.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
// Function
// - clock source bit picks bus or oscillator
// - mode field: operation, reset, halt; 11 ignored
// - sleep bit enters sleep, clear leaves it
// - bus-off recovery policy selects halt entry
// - forced bus-off return bit pulses return
// - mailbox mode bit selects normal or fifo
// - id format: standard, extended, mixed; 11 ignored
// - full mailbox: overwrite or discard new
// - transmit order by id or mailbox
// - time stamp reset bit clears counter
// - time stamp advances every 1/2/4/8 bits
// - reset flag reads one in reset
// - halt flag reads one in halt
// - sleep flag reads one in sleep
// - eight acceptance masks, individually enabled
// - bus-off flag mirrors bus-off state
// - error-passive flag mirrors error-passive state
// - receive fifo flag when fifo holds message
// - baud prescaler divides protocol clock by value+1
module cmc_mode_ctrl #(
  parameter int unsigned AW = 18              // wishbone byte address width
) (
  input  wire logic               clock_i,          // 250 MHz system clock
  input  wire logic               rst_b_i,          // async reset, active low
  input  wire logic               ce_i,             // clock enable, freezes all state
  // wishbone classic slave
  input  wire logic               wb_cyc_i,         // bus cycle
  input  wire logic               wb_stb_i,         // strobe
  input  wire logic               wb_we_i,          // write enable
  input  wire logic [AW-1:0]      wb_adr_i,         // byte address
  input  wire logic [3:0]         wb_sel_i,         // byte lane selects
  input  wire logic [31:0]        wb_dat_i,         // write data
  output logic      [31:0]        wb_dat_o,         // read data
  output logic                    wb_ack_o,         // acknowledge
  // oscillator pin and protocol engine
  input  wire logic               main_osc_i,       // main oscillator pin, async
  input  wire logic               bus_idle_i,       // engine: no frame in progress
  input  wire logic               bit_tick_i,       // engine: one pulse per bit time
  input  wire logic               bus_off_i,        // engine: in bus-off state
  input  wire logic               err_passive_i,    // engine: error-passive
  input  wire logic               tx_active_i,      // engine: transmitting
  input  wire logic               rx_active_i,      // engine: receiving
  input  wire logic               rx_fifo_nempty_i, // engine: rx fifo holds a message
  input  wire logic               rx_arrive_i,      // engine: message for a mailbox
  input  wire logic               rx_box_full_i,    // engine: target mailbox unread
  // towards the protocol engine
  output cmc_pkg::cmc_mode_t      mode_o,           // completed operating mode
  output cmc_pkg::cmc_ctrl_t      ctrl_o,           // stored configuration
  output logic                    clk_src_o,        // 0 bus clock, 1 main oscillator
  output logic                    tq_tick_o,        // prescaled protocol clock pulse
  output logic      [7:0]         mask_en_o,        // acceptance mask enables
  output logic      [15:0]        time_stamp_o,     // time stamp counter
  output logic                    busoff_ret_o,     // pulse: leave bus-off
  output logic                    rx_store_o,       // pulse: store arriving message
  output logic                    rx_overrun_o      // pulse: arriving message dropped
);

  // ==========================================================================
  // helpers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    merge16 = old_v;
    if (sel[0])
    begin
      merge16[7:0] = new_v[7:0];
    end
    if (sel[1])
    begin
      merge16[15:8] = new_v[15:8];
    end
  endfunction : merge16

  function automatic cmc_pkg::cmc_mode_t target_mode(input cmc_pkg::cmc_ctrl_t c);
    if (c.sleep)
    begin
      target_mode = cmc_pkg::CMC_SLEEP;
    end
    else if (c.mode == cmc_pkg::MODE_OPER)
    begin
      target_mode = cmc_pkg::CMC_OPER;
    end
    else if (c.mode == cmc_pkg::MODE_HALT)
    begin
      target_mode = cmc_pkg::CMC_HALT;
    end
    else
    begin
      target_mode = cmc_pkg::CMC_RESET;
    end
  endfunction : target_mode

  // ==========================================================================
  // bus decode
  logic        acc;
  logic        wr;
  logic [15:0] idx;
  logic [15:0] wdat;
  logic [1:0]  wsel;

  // ack comes one cycle after the strobe and drops the cycle after
  assign acc  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr   = acc & wb_we_i;
  assign idx  = wb_adr_i[AW-1:2];
  assign wdat = wb_dat_i[15:0];
  assign wsel = wb_sel_i[1:0];

  logic        wr_ctrl;
  logic [15:0] ctrl_wv;

  assign wr_ctrl = wr & (idx == cmc_pkg::IDX_CONTROL);
  assign ctrl_wv = merge16(ctrl_o, wdat, wsel);

  // ==========================================================================
  // pin synchroniser and bus-off edge history
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic bus_off_d;

  // osc_s1 is read only by osc_s2; the edge uses later stages
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      osc_s1    <= 1'b0;
      osc_s2    <= 1'b0;
      osc_s3    <= 1'b0;
      bus_off_d <= 1'b0;
    end
    else if (ce_i)
    begin
      osc_s1    <= main_osc_i;
      osc_s2    <= osc_s1;
      osc_s3    <= osc_s2;
      bus_off_d <= bus_off_i;
    end
  end

  logic bo_entry;
  logic bo_end;

  assign bo_entry = bus_off_i & ~bus_off_d;
  assign bo_end   = ~bus_off_i & bus_off_d;

  // ==========================================================================
  // control register
  logic auto_halt;

  // policy 11 leaves halt entry to a software write of the mode field
  assign auto_halt = ((ctrl_o.busoff_mode == cmc_pkg::BOR_ENTRY) & bo_entry) |
                     ((ctrl_o.busoff_mode == cmc_pkg::BOR_END) & bo_end);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_o <= cmc_pkg::CTRL_RESET;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        ctrl_o.ts_pre      <= ctrl_wv[15:14];
        ctrl_o.tx_prio     <= ctrl_wv[12];
        ctrl_o.msg_lost    <= ctrl_wv[11];
        ctrl_o.mbox_fifo   <= ctrl_wv[8];
        ctrl_o.busoff_mode <= ctrl_wv[4:3];
        ctrl_o.sleep       <= ctrl_wv[2];
        // forbidden codes keep the previous setting
        if (ctrl_wv[10:9] != cmc_pkg::IDF_BAD)
        begin
          ctrl_o.id_fmt <= ctrl_wv[10:9];
        end
        if (ctrl_wv[1:0] != cmc_pkg::MODE_BAD)
        begin
          ctrl_o.mode <= ctrl_wv[1:0];
        end
      end
      // hardware halt entry wins over a same-cycle software write
      if (auto_halt)
      begin
        ctrl_o.mode <= cmc_pkg::MODE_HALT;
      end
    end
  end

  // one-shot commands, never stored
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busoff_ret_o <= 1'b0;
    end
    else if (ce_i)
    begin
      busoff_ret_o <= wr_ctrl & ctrl_wv[cmc_pkg::POS_FORCE_RET];
    end
  end

  // ==========================================================================
  // other writable registers
  logic [9:0]  brp;
  logic [15:0] brp_wv;

  // merged into a wire first: a function result cannot be part-selected
  assign brp_wv = merge16({6'h00, brp}, wdat, wsel);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      brp       <= cmc_pkg::BRP_RESET;
      clk_src_o <= 1'b0;
      mask_en_o <= cmc_pkg::MASK_EN_RESET;
    end
    else if (ce_i && wr)
    begin
      if (idx == cmc_pkg::IDX_BIT_TIMING)
      begin
        brp <= brp_wv[9:0];
      end
      if (idx == cmc_pkg::IDX_CLOCK_SEL && wsel[0])
      begin
        clk_src_o <= wdat[0];
      end
      if (idx == cmc_pkg::IDX_MASK_EN && wsel[0])
      begin
        mask_en_o <= wdat[7:0];
      end
    end
  end

  // ==========================================================================
  // mode sequencing: a change completes only between frames
  cmc_pkg::cmc_mode_t want;

  assign want = target_mode(ctrl_o);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_o <= cmc_pkg::CMC_RESET;
    end
    else if (ce_i)
    begin
      case (mode_o)
        cmc_pkg::CMC_OPER,
        cmc_pkg::CMC_RESET,
        cmc_pkg::CMC_HALT,
        cmc_pkg::CMC_SLEEP:
        begin
          if (want != mode_o && bus_idle_i)
          begin
            mode_o <= want;
          end
        end
        default:
        begin
          mode_o <= cmc_pkg::CMC_RESET;
        end
      endcase
    end
  end

  // ==========================================================================
  // protocol clock prescaler, bus clock or synchronised oscillator edge
  logic       pclk_tick;
  logic [9:0] brp_cnt;

  assign pclk_tick = clk_src_o ? (osc_s2 & ~osc_s3) : 1'b1;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      brp_cnt   <= 10'h000;
      tq_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      tq_tick_o <= 1'b0;
      if (pclk_tick)
      begin
        if (brp_cnt >= brp)
        begin
          brp_cnt   <= 10'h000;
          tq_tick_o <= 1'b1;
        end
        else
        begin
          brp_cnt <= brp_cnt + 10'h001;
        end
      end
    end
  end

  // ==========================================================================
  // time stamp counter; reset beats a coincident advance
  logic [2:0] ts_div;
  logic [2:0] ts_lim;

  assign ts_lim = 3'((4'h1 << ctrl_o.ts_pre) - 4'h1);  // 0,1,3,7

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ts_div       <= 3'h0;
      time_stamp_o <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (wr_ctrl && ctrl_wv[cmc_pkg::POS_TS_RESET])
      begin
        ts_div       <= 3'h0;
        time_stamp_o <= 16'h0000;
      end
      else if (bit_tick_i)
      begin
        if (ts_div >= ts_lim)
        begin
          ts_div       <= 3'h0;
          time_stamp_o <= time_stamp_o + 16'h0001;
        end
        else
        begin
          ts_div <= ts_div + 3'h1;
        end
      end
    end
  end

  // ==========================================================================
  // receive mailbox policy when the box still holds unread data
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_store_o   <= 1'b0;
      rx_overrun_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rx_store_o   <= rx_arrive_i & ~(rx_box_full_i & ctrl_o.msg_lost);
      rx_overrun_o <= rx_arrive_i & rx_box_full_i & ctrl_o.msg_lost;
    end
  end

  // ==========================================================================
  // status and read mux
  logic [15:0] status;
  logic [15:0] rdat;

  always_comb
  begin
    status = 16'h0000;
    status[cmc_pkg::POS_ST_RESET]  = (mode_o == cmc_pkg::CMC_RESET);
    status[cmc_pkg::POS_ST_HALT]   = (mode_o == cmc_pkg::CMC_HALT);
    status[cmc_pkg::POS_ST_SLEEP]  = (mode_o == cmc_pkg::CMC_SLEEP);
    status[cmc_pkg::POS_ST_ERRPAS] = err_passive_i;
    status[cmc_pkg::POS_ST_BUSOFF] = bus_off_i;
    status[cmc_pkg::POS_ST_TXACT]  = tx_active_i;
    status[cmc_pkg::POS_ST_RXACT]  = rx_active_i;
    status[cmc_pkg::POS_ST_RXFIFO] = rx_fifo_nempty_i;
  end

  // unmapped addresses answer with zero data
  always_comb
  begin
    case (idx)
      cmc_pkg::IDX_CONTROL:    rdat = ctrl_o;
      cmc_pkg::IDX_STATUS:     rdat = status;
      cmc_pkg::IDX_BIT_TIMING: rdat = {6'h00, brp};
      cmc_pkg::IDX_CLOCK_SEL:  rdat = {15'h0000, clk_src_o};
      cmc_pkg::IDX_TIME_STAMP: rdat = time_stamp_o;
      cmc_pkg::IDX_MASK_EN:    rdat = {8'h00, mask_en_o};
      default:                 rdat = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i)
      begin
        wb_dat_o <= {16'h0000, rdat};
      end
    end
  end

endmodule : cmc_mode_ctrl

// file: verification/cmc_mode_ctrl_properties.sv
`timescale 1ns/1ps
module cmc_mode_ctrl_properties #(
  parameter int unsigned AW = 18           // byte address width
) (
  input wire logic               clock_i,          // system clock
  input wire logic               rst_b_i,          // async reset, active low
  input wire logic               ce_i,             // clock enable
  input wire logic               wb_cyc_i,         // bus cycle
  input wire logic               wb_stb_i,         // strobe
  input wire logic               wb_we_i,          // write enable
  input wire logic [AW-1:0]      wb_adr_i,         // byte address
  input wire logic [3:0]         wb_sel_i,         // byte lanes
  input wire logic [31:0]        wb_dat_i,         // write data
  input wire logic [31:0]        wb_dat_o,         // read data
  input wire logic               wb_ack_o,         // acknowledge
  input wire logic               bus_idle_i,       // no frame
  input wire logic               bit_tick_i,       // bit time pulse
  input wire logic               bus_off_i,        // bus-off level
  input wire logic               err_passive_i,    // error-passive level
  input wire logic               rx_fifo_nempty_i, // rx fifo holds data
  input wire logic               rx_arrive_i,      // arrival pulse
  input wire logic               rx_box_full_i,    // target unread
  input wire cmc_pkg::cmc_mode_t mode_o,           // completed mode
  input wire cmc_pkg::cmc_ctrl_t ctrl_o,           // stored control
  input wire logic               clk_src_o,        // clock source
  input wire logic [7:0]         mask_en_o,        // mask enables
  input wire logic [15:0]        time_stamp_o,     // time stamp
  input wire logic               busoff_ret_o,     // leave bus-off pulse
  input wire logic               rx_store_o,       // store pulse
  input wire logic               rx_overrun_o      // drop pulse
);
  // ==========================================================================
  // decoded accesses at the edge where the slave takes them
  logic        take;
  logic        wr_c;
  logic        wr_k;
  logic        wr_m;
  logic        rd_s;
  logic        wr_t;
  logic [15:0] idx;
  assign idx  = wb_adr_i[AW-1:2];
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign wr_c = take && wb_we_i && wb_sel_i[0] && idx == cmc_pkg::IDX_CONTROL;
  assign wr_k = take && wb_we_i && wb_sel_i[0] && idx == cmc_pkg::IDX_CLOCK_SEL;
  assign wr_m = take && wb_we_i && wb_sel_i[0] && idx == cmc_pkg::IDX_MASK_EN;
  assign rd_s = take && !wb_we_i && idx == cmc_pkg::IDX_STATUS;
  // the time stamp reset bit sits in the high byte lane
  assign wr_t = take && wb_we_i && wb_sel_i[1] && idx == cmc_pkg::IDX_CONTROL && wb_dat_i[13];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================================
  // assertions
  mode_idle_a : assert property ($changed(mode_o) |-> $past(bus_idle_i) && $past(ce_i))
    else $error("mode moved while a frame was on the bus");
  ret_pulse_a : assert property (wr_c && wb_dat_i[5] |=> busoff_ret_o)
    else $error("no bus-off return pulse");
  rx_drop_a : assert property (rx_arrive_i && ce_i && rx_box_full_i && ctrl_o.msg_lost
    |=> rx_overrun_o && !rx_store_o) else $error("full box not dropped");
  rx_keep_a : assert property (rx_arrive_i && ce_i && !(rx_box_full_i && ctrl_o.msg_lost)
    |=> rx_store_o && !rx_overrun_o) else $error("arrival not stored");
  mode_flags_a : assert property (rd_s |=> wb_ack_o && wb_dat_o[2:0] ==
    {$past(mode_o) == cmc_pkg::CMC_SLEEP, $past(mode_o) == cmc_pkg::CMC_HALT,
     $past(mode_o) == cmc_pkg::CMC_RESET}) else $error("mode flags wrong");
  live_flags_a : assert property (rd_s |=> {wb_dat_o[10], wb_dat_o[4:3]} ==
    {$past(rx_fifo_nempty_i), $past(bus_off_i), $past(err_passive_i)})
    else $error("live flags wrong");
  ts_clear_a : assert property (wr_t |=> time_stamp_o == 16'h0000)
    else $error("time stamp not cleared");
  ts_hold_a : assert property (!bit_tick_i && !wr_t && ce_i
    |=> $stable(time_stamp_o)) else $error("time stamp moved without a bit time");
  entry_halt_a : assert property (ctrl_o.busoff_mode == cmc_pkg::BOR_ENTRY &&
    $rose(bus_off_i) |-> ##[1:3] ctrl_o.mode == cmc_pkg::MODE_HALT) else $error("no halt");
  src_sel_a : assert property (wr_k |=> clk_src_o == $past(wb_dat_i[0]))
    else $error("clock source not taken");
  mask_en_a : assert property (wr_m |=> mask_en_o == $past(wb_dat_i[7:0]))
    else $error("mask enables not taken");
  bad_mode_a : assert property (wr_c && wb_dat_i[1:0] == cmc_pkg::MODE_BAD &&
    wb_dat_i[4:3] == 2'h0 && ctrl_o.busoff_mode == cmc_pkg::BOR_NORMAL
    |=> ctrl_o.mode == $past(ctrl_o.mode)) else $error("forbidden mode stored");

  // main scenarios reached
  cover property (rx_overrun_o);
  cover property (busoff_ret_o);
  cover property (mode_o == cmc_pkg::CMC_SLEEP);
endmodule : cmc_mode_ctrl_properties

// file: verification/cmc_far_end.sv
`timescale 1ns/1ps
module cmc_far_end (
  input  wire logic clock_i,    // system clock
  input  wire logic rst_b_i,    // async reset, active low
  input  wire logic busy_i,     // a frame is wanted on the bus
  output logic      bus_idle_o, // no frame in progress
  output logic      bit_tick_o, // one pulse per bit time
  output logic      main_osc_o  // oscillator, one rise per four cycles
);
  logic [1:0] ph;
  // ==========================================================================
  // bit timing and oscillator share one phase counter, so rates are exact
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i) begin ph <= 2'h0; bit_tick_o <= 1'b0; main_osc_o <= 1'b0; end
    else begin ph <= ph + 2'h1; bit_tick_o <= ph == 2'h3; main_osc_o <= ph[1]; end
  end
  // frame activity follows the bench one cycle late, like a real line
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i) bus_idle_o <= 1'b1;
    else bus_idle_o <= !busy_i;
  end
endmodule : cmc_far_end

// file: verification/cmc_mode_ctrl_bench.sv
`timescale 1ns/1ps
module cmc_mode_ctrl_bench;
  localparam logic [15:0] CT = cmc_pkg::IDX_CONTROL;
  localparam logic [15:0] ST = cmc_pkg::IDX_STATUS;
  localparam logic [15:0] BT = cmc_pkg::IDX_BIT_TIMING;
  localparam logic [15:0] CK = cmc_pkg::IDX_CLOCK_SEL;
  localparam logic [15:0] MK = cmc_pkg::IDX_MASK_EN;
  localparam logic [15:0] MC [4] = '{16'h0000, 16'h0002, 16'h0001, 16'h0004};
  localparam logic [15:0] MF [4] = '{16'h0000, 16'h0002, 16'h0001, 16'h0004};
  logic clock_i, rst_b_i, cyc, stb, we, busy, bus_off, err_pas, fifo_ne, arrive, full;
  logic idle, tick, osc, clk_src_o, tq_tick_o, busoff_ret_o, rx_store_o, rx_overrun_o;
  logic               tx_act, rx_act;
  logic               wb_ack_o;
  logic [17:0]        adr;
  logic [31:0]        wdat, rd, wb_dat_o;
  logic [7:0]         mask_en_o;
  logic [15:0]        time_stamp_o;
  cmc_pkg::cmc_mode_t mode_o;
  cmc_pkg::cmc_ctrl_t ctrl_o;
  int                 n_fail, n_compared, c;

  cmc_mode_ctrl dut_u (.clock_i, .rst_b_i, .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
    .main_osc_i(osc), .bus_idle_i(idle), .bit_tick_i(tick), .bus_off_i(bus_off),
    .err_passive_i(err_pas), .tx_active_i(tx_act), .rx_active_i(rx_act),
    .rx_fifo_nempty_i(fifo_ne), .rx_arrive_i(arrive), .rx_box_full_i(full), .mode_o,
    .ctrl_o, .clk_src_o, .tq_tick_o, .mask_en_o, .time_stamp_o, .busoff_ret_o, .rx_store_o,
    .rx_overrun_o);
  cmc_far_end far_u (.clock_i, .rst_b_i, .busy_i(busy), .bus_idle_o(idle),
    .bit_tick_o(tick), .main_osc_o(osc));

  // ==========================================================================
  // clock, 4 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin n_fail++; $display("[ERR] %0t saw %h want %h", $time, s, e); end
  endtask : chk

  // one classic cycle, held until ack is sampled high
  task automatic acc(input logic w, input logic [15:0] i, input logic [15:0] d);
    int n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {16'h0000, d};
    do begin @(posedge clock_i); n++; end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    if (n >= 40) begin n_fail++; $display("[ERR] %0t no ack", $time); end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : acc

  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    acc(1'b1, i, d);
  endtask : wr

  task automatic rdc(input logic [15:0] i, input logic [15:0] m, input logic [15:0] e);
    acc(1'b0, i, 16'h0000);
    chk(rd & {16'hFFFF, m}, {16'h0000, e});
  endtask : rdc

  // arrival pulse, result looked at in the cycle after
  task automatic rxp(input logic f, input logic e);
    @(posedge clock_i);
    arrive <= 1'b1;
    full <= f;
    @(posedge clock_i);
    arrive <= 1'b0;
    @(posedge clock_i);
    chk({30'h0, rx_overrun_o, rx_store_o}, {30'h0, e, !e});
  endtask : rxp

  task automatic cnt_tq(input int n);
    c = 0;
    repeat (n) begin @(posedge clock_i); if (tq_tick_o === 1'b1) c++; end
  endtask : cnt_tq

  task automatic report_and_stop;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // tests
  initial
  begin
    {rst_b_i, cyc, stb, we, busy, bus_off, err_pas, fifo_ne, arrive, full} = '0;
    {tx_act, rx_act} = 2'h0;
    adr = '0;
    wdat = '0;
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rdc(CT, 16'hFFFF, 16'h0001);
    rdc(ST, 16'h0007, 16'h0001);
    rdc(MK, 16'h00FF, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin wr(CT, MC[i]); rdc(ST, 16'h0007, MF[i]); end
    wr(CT, 16'h0002);
    wr(CT, 16'h0003);
    rdc(CT, 16'h0003, 16'h0002);
    rdc(ST, 16'h0007, 16'h0002);
    $display("test modes done");
    wr(CT, 16'h0000);
    busy <= 1'b1;
    repeat (3) @(posedge clock_i);
    wr(CT, 16'h0002);
    rdc(ST, 16'h0007, 16'h0000);
    busy <= 1'b0;
    repeat (3) @(posedge clock_i);
    rdc(ST, 16'h0007, 16'h0002);
    $display("test busy bus done");
    wr(CT, 16'h5500);
    rdc(CT, 16'hFFFF, 16'h5500);
    wr(CT, 16'h5700);
    rdc(CT, 16'hFFFF, 16'h5500);
    wr(CT, 16'h0800);
    rxp(1'b1, 1'b1);
    rxp(1'b0, 1'b0);
    wr(CT, 16'h0000);
    rxp(1'b1, 1'b0);
    $display("test fields and arrivals done");
    wr(CT, 16'hA000);
    c = 0;
    while (c < 8) begin @(posedge clock_i); if (tick === 1'b1) c++; end
    @(posedge clock_i);
    chk({16'h0, time_stamp_o}, 32'h2);
    wr(CT, 16'h2000);
    chk({16'h0, time_stamp_o}, 32'h0);
    rdc(CT, 16'h2000, 16'h0000);
    wr(CT, 16'h0020);
    chk({31'h0, busoff_ret_o}, 32'h1);
    rdc(CT, 16'h0020, 16'h0000);
    $display("test time stamp and return done");
    wr(CT, 16'h0008);
    bus_off <= 1'b1;
    err_pas <= 1'b1;
    fifo_ne <= 1'b1;
    tx_act <= 1'b1;
    rx_act <= 1'b1;
    repeat (4) @(posedge clock_i);
    rdc(CT, 16'h001F, 16'h000A);
    rdc(ST, 16'h047F, 16'h047A);
    {bus_off, err_pas, fifo_ne, tx_act, rx_act} <= 5'h00;
    wr(CT, 16'h0000);
    rdc(ST, 16'h047F, 16'h0000);
    $display("test bus-off done");
    wr(CK, 16'h0000);
    wr(BT, 16'h0003);
    rdc(BT, 16'h03FF, 16'h0003);
    cnt_tq(40);
    chk(32'(c), 32'hA);
    wr(CK, 16'h0001);
    rdc(CK, 16'h0001, 16'h0001);
    wr(BT, 16'h0000);
    cnt_tq(40);
    chk(32'(c >= 9 && c <= 11), 32'h1);
    wr(MK, 16'h00A5);
    rdc(MK, 16'h00FF, 16'h00A5);
    rdc(16'h0001, 16'hFFFF, 16'h0000);
    $display("test clocks and masks done");
    report_and_stop;
  end

  // a hang is cut short well past the expected run time
  initial
  begin
    #100000;
    n_fail++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule : cmc_mode_ctrl_bench

bind cmc_mode_ctrl cmc_mode_ctrl_properties #(.AW(AW)) chk_u (.clock_i, .rst_b_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .bus_idle_i, .bit_tick_i, .bus_off_i, .err_passive_i, .rx_fifo_nempty_i, .rx_arrive_i,
  .rx_box_full_i, .mode_o, .ctrl_o, .clk_src_o, .mask_en_o, .time_stamp_o, .busoff_ret_o,
  .rx_store_o, .rx_overrun_o);
